// ===== core/srapi_core.sv
// real-time clock core: calendar, alarms, periodic irq, two-wire target, avalon slave
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module srapi_core #(
    parameter int OSC_HALT_CYCLES = srapi_pkg::OSC_HALT_CYC,
    parameter logic [15:0] PRESC_TOP = srapi_pkg::PRESC_TOP,
    parameter logic [6:0] I2C_ADDR = srapi_pkg::DEV_ADDR
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_xtal,
    input wire logic i_vdet_low,
    input wire logic i_vdet_high,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_periodic_irq_out_oe,
    output logic o_weekly_alarm_irq_out_oe,
    output logic o_daily_alarm_irq_out_oe,
    output logic o_khz_clock_out_oe,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    localparam int B_PM_L = srapi_pkg::B_PM;

    // --------------------------------------------------------------
    // bcd helpers
    // --------------------------------------------------------------

    // increment a two-digit bcd value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // last day of a month; february gets 29 in years divisible by four
    function automatic logic [7:0] last_day(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        logic [7:0] d;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        d = 8'h31;
        if (mon == 5'h02) begin
            d = leap ? 8'h29 : 8'h28;
        end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
            d = 8'h30;
        end
        return d;
    endfunction

    // one hour step; top bit of the result flags the day rollover
    function automatic logic [8:0] hour_step(input logic [7:0] h, input logic mode24);
        logic [8:0] r;
        r = {1'b0, bcd_inc(h)};
        if (mode24) begin
            if (h == 8'h23) begin
                r = {1'b1, 8'h00};
            end
        end else begin
            // 12-hour: 12 follows 11 with am/pm swap, 01 follows 12
            if (h[4:0] == 5'h11) begin
                r = {h[B_PM_L], 8'h12 | {2'b00, ~h[B_PM_L], 5'h00}};
            end else if (h[4:0] == 5'h12) begin
                r = {1'b0, 2'b00, h[B_PM_L], 5'h01};
            end else begin
                r = {1'b0, 2'b00, h[B_PM_L], 5'(bcd_inc({3'b000, h[4:0]}))};
            end
        end
        return r;
    endfunction

    srapi_pkg::srapi_state_s st;
    srapi_pkg::srapi_state_s next_st;

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    always_comb begin
        logic [15:0][7:0] r;
        logic xtal_rise;
        logic scl_rise;
        logic scl_fall;
        logic sda_lvl;
        logic start_c;
        logic stop_c;
        logic half_tick;
        logic sec_tick;
        logic min_tick;
        logic hour_tick;
        logic day_tick;
        logic month_tick;
        logic [15:0] top;
        logic [8:0] hs;
        logic [7:0] ctrl;
        logic [7:0] set_f;
        logic i2c_we;
        logic [3:0] i2c_idx;
        logic [7:0] i2c_data;
        logic av_we;
        logic [7:0] wdata;
        logic hit;
        next_st = st;
        r = st.regs;
        ctrl = st.regs[srapi_pkg::R_CTRL];
        half_tick = 1'b0;
        sec_tick = 1'b0;
        min_tick = 1'b0;
        hour_tick = 1'b0;
        day_tick = 1'b0;
        month_tick = 1'b0;
        set_f = 8'h00;
        i2c_we = 1'b0;
        i2c_idx = 4'h0;
        i2c_data = 8'h00;
        hs = 9'h000;
        wdata = 8'h00;
        hit = 1'b0;

        // synchronisers; stage 0 feeds stage 1 only
        next_st.xtal_sync = {st.xtal_sync[1:0], i_xtal};
        next_st.scl_sync = {st.scl_sync[1:0], i_scl};
        next_st.sda_sync = {st.sda_sync[1:0], i_sda};
        next_st.vlo_sync = {st.vlo_sync[0], i_vdet_low};
        next_st.vhi_sync = {st.vhi_sync[0], i_vdet_high};
        xtal_rise = st.xtal_sync[1] & ~st.xtal_sync[2];
        scl_rise = st.scl_sync[1] & ~st.scl_sync[2];
        scl_fall = ~st.scl_sync[1] & st.scl_sync[2];
        sda_lvl = st.sda_sync[1];
        start_c = st.scl_sync[1] & st.scl_sync[2] & ~st.sda_sync[1] & st.sda_sync[2];
        stop_c = st.scl_sync[1] & st.scl_sync[2] & st.sda_sync[1] & ~st.sda_sync[2];

        // clock output follows the crystal unless switched off
        next_st.khz_oe = ~ctrl[srapi_pkg::B_KHZ_OFF] & ~st.xtal_sync[1];

        // -------- prescaler with frequency correction --------
        // the correction is applied once every ten seconds by stretching or
        // shortening that second by the programmed number of crystal ticks
        top = PRESC_TOP;
        if (r[srapi_pkg::R_SEC][3:0] == 4'h0) begin
            if (r[srapi_pkg::R_ADJUST][srapi_pkg::B_ADJ_SIGN]) begin
                top = PRESC_TOP + {10'h000, r[srapi_pkg::R_ADJUST][5:0]};
            end else begin
                top = PRESC_TOP - {10'h000, r[srapi_pkg::R_ADJUST][5:0]};
            end
        end
        if (xtal_rise) begin
            if (st.presc >= top) begin
                next_st.presc = 16'h0000;
                sec_tick = 1'b1;
            end else begin
                next_st.presc = st.presc + 16'h0001;
                half_tick = (st.presc == (PRESC_TOP >> 1));
            end
        end

        // -------- oscillator stoppage watch --------
        if (xtal_rise) begin
            next_st.osc_cnt = 16'h0000;
        end else if (st.osc_cnt != 16'(OSC_HALT_CYCLES)) begin
            next_st.osc_cnt = st.osc_cnt + 16'h0001;
        end
        if (st.osc_cnt == 16'(OSC_HALT_CYCLES - 1)) begin
            set_f[srapi_pkg::B_F_OSCHALT] = 1'b1;
        end

        // -------- bcd time and calendar chain --------
        if (sec_tick) begin
            if (r[srapi_pkg::R_SEC] == 8'h59) begin
                r[srapi_pkg::R_SEC] = 8'h00;
                min_tick = 1'b1;
                if (r[srapi_pkg::R_MIN] == 8'h59) begin
                    r[srapi_pkg::R_MIN] = 8'h00;
                    hour_tick = 1'b1;
                    hs = hour_step(r[srapi_pkg::R_HOUR], ctrl[srapi_pkg::B_MODE24]);
                    r[srapi_pkg::R_HOUR] = hs[7:0];
                    day_tick = hs[8];
                end else begin
                    r[srapi_pkg::R_MIN] = bcd_inc(r[srapi_pkg::R_MIN]);
                end
            end else begin
                r[srapi_pkg::R_SEC] = bcd_inc(r[srapi_pkg::R_SEC]);
            end
        end
        if (day_tick) begin
            r[srapi_pkg::R_WDAY] = (r[srapi_pkg::R_WDAY][2:0] == 3'h6) ? 8'h00
                                 : r[srapi_pkg::R_WDAY] + 8'h01;
            if (r[srapi_pkg::R_DAY] == last_day(r[srapi_pkg::R_MONTH][4:0],
                                               r[srapi_pkg::R_YEAR])) begin
                r[srapi_pkg::R_DAY] = 8'h01;
                month_tick = 1'b1;
            end else begin
                r[srapi_pkg::R_DAY] = bcd_inc(r[srapi_pkg::R_DAY]);
            end
        end
        if (month_tick) begin
            if (r[srapi_pkg::R_MONTH][4:0] == 5'h12) begin
                r[srapi_pkg::R_MONTH][4:0] = 5'h01;
                if (r[srapi_pkg::R_YEAR] == 8'h99) begin
                    r[srapi_pkg::R_YEAR] = 8'h00;
                    r[srapi_pkg::R_MONTH][srapi_pkg::B_CENTURY] =
                        ~r[srapi_pkg::R_MONTH][srapi_pkg::B_CENTURY];
                end else begin
                    r[srapi_pkg::R_YEAR] = bcd_inc(r[srapi_pkg::R_YEAR]);
                end
            end else begin
                r[srapi_pkg::R_MONTH][4:0] = 5'(bcd_inc({3'b000, r[srapi_pkg::R_MONTH][4:0]}));
            end
        end

        // -------- alarms, checked on the new minute --------
        if (min_tick && ctrl[srapi_pkg::B_WK_EN]
                && r[srapi_pkg::R_WK_MIN] == r[srapi_pkg::R_MIN]
                && r[srapi_pkg::R_WK_HOUR] == r[srapi_pkg::R_HOUR]
                && r[srapi_pkg::R_WK_DAYS][r[srapi_pkg::R_WDAY][2:0]]) begin
            set_f[srapi_pkg::B_F_WK] = 1'b1;
        end
        if (min_tick && ctrl[srapi_pkg::B_DY_EN]
                && r[srapi_pkg::R_DY_MIN] == r[srapi_pkg::R_MIN]
                && r[srapi_pkg::R_DY_HOUR] == r[srapi_pkg::R_HOUR]) begin
            set_f[srapi_pkg::B_F_DY] = 1'b1;
        end

        // -------- periodic interrupt source --------
        case (ctrl[2:0])
            srapi_pkg::PER_HALF_SEC: set_f[srapi_pkg::B_F_PER] = half_tick | sec_tick;
            srapi_pkg::PER_SEC: set_f[srapi_pkg::B_F_PER] = sec_tick;
            srapi_pkg::PER_MIN: set_f[srapi_pkg::B_F_PER] = min_tick;
            srapi_pkg::PER_HOUR: set_f[srapi_pkg::B_F_PER] = hour_tick;
            srapi_pkg::PER_DAY: set_f[srapi_pkg::B_F_PER] = day_tick;
            srapi_pkg::PER_MONTH: set_f[srapi_pkg::B_F_PER] = month_tick;
            default: set_f[srapi_pkg::B_F_PER] = 1'b0;
        endcase

        // -------- supply drop record --------
        // the comparator is asynchronous, hence the two-stage sampling
        if (ctrl[srapi_pkg::B_VDET_SEL] ? st.vhi_sync[1] : st.vlo_sync[1]) begin
            set_f[srapi_pkg::B_F_VDET] = 1'b1;
        end

        // -------- two-wire target --------
        // bits are taken on rising scl and changed on falling scl
        if (start_c) begin
            next_st.i2c_st = srapi_pkg::I2C_ADDR;
            next_st.bitcnt = 4'h0;
            next_st.ack_ph = 1'b0;
            next_st.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_st.i2c_st = srapi_pkg::I2C_IDLE;
            next_st.sda_oe = 1'b0;
        end else if (st.i2c_st != srapi_pkg::I2C_IDLE) begin
            if (scl_rise) begin
                if (st.ack_ph) begin
                    next_st.nack = sda_lvl;
                end else begin
                    next_st.shreg = {st.shreg[6:0], sda_lvl};
                    next_st.bitcnt = st.bitcnt + 4'h1;
                end
            end else if (scl_fall) begin
                if (st.ack_ph) begin
                    next_st.ack_ph = 1'b0;
                    next_st.sda_oe = 1'b0;
                    if (st.i2c_st == srapi_pkg::I2C_READ) begin
                        if (st.nack) begin
                            next_st.i2c_st = srapi_pkg::I2C_IDLE;
                        end else begin
                            next_st.shreg = st.regs[st.ptr];
                            next_st.sda_oe = ~st.regs[st.ptr][7];
                            next_st.ptr = st.ptr + 4'h1;
                        end
                    end
                end else if (st.bitcnt == 4'h8) begin
                    next_st.bitcnt = 4'h0;
                    next_st.ack_ph = 1'b1;
                    next_st.sda_oe = 1'b1;
                    unique case (st.i2c_st)
                        srapi_pkg::I2C_IDLE: next_st.sda_oe = 1'b0;
                        srapi_pkg::I2C_ADDR: begin
                            if (st.shreg[7:1] == I2C_ADDR) begin
                                next_st.i2c_st = st.shreg[0] ? srapi_pkg::I2C_READ
                                                             : srapi_pkg::I2C_WORD;
                            end else begin
                                next_st.i2c_st = srapi_pkg::I2C_IDLE;
                                next_st.sda_oe = 1'b0;
                            end
                        end
                        srapi_pkg::I2C_WORD: begin
                            next_st.ptr = st.shreg[3:0];
                            next_st.i2c_st = srapi_pkg::I2C_DATA;
                        end
                        srapi_pkg::I2C_DATA: begin
                            i2c_we = 1'b1;
                            i2c_idx = st.ptr;
                            i2c_data = st.shreg;
                            next_st.ptr = st.ptr + 4'h1;
                        end
                        srapi_pkg::I2C_READ: next_st.sda_oe = 1'b0;
                    endcase
                end else if (st.i2c_st == srapi_pkg::I2C_READ) begin
                    next_st.sda_oe = ~st.shreg[7];
                end
            end
        end

        // -------- avalon slave: one wait state on every access --------
        next_st.av_ack = (i_avs_read | i_avs_write) & ~st.av_ack;
        if ((i_avs_read | i_avs_write) && !st.av_ack) begin
            next_st.av_rdata = {24'h000000, st.regs[i_avs_address]};
        end
        av_we = i_avs_write & st.av_ack;

        // -------- register writes; avalon wins a same-register clash --------
        for (int i = 0; i < 16; i++) begin
            hit = 1'b0;
            wdata = 8'h00;
            if (av_we && i_avs_address == 4'(i)) begin
                hit = 1'b1;
                wdata = i_avs_writedata[7:0];
            end else if (i2c_we && i2c_idx == 4'(i)) begin
                hit = 1'b1;
                wdata = i2c_data;
            end
            if (4'(i) == srapi_pkg::R_FLAGS) begin
                // writing zero clears a flag, a new event in that cycle still sets it
                if (hit) begin
                    r[i] = r[i] & wdata;
                end
                r[i] = r[i] | set_f;
            end else if (hit && 4'(i) != srapi_pkg::R_RSVD) begin
                r[i] = wdata;
                if (4'(i) == srapi_pkg::R_SEC) begin
                    next_st.presc = 16'h0000; // a fresh second starts on a seconds write
                end
            end
        end
        next_st.regs = r;
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0; // interrupt flag bits clear so every interrupt pin is released
            st.scl_sync <= 3'h7; // idle-high lines, so no false edge after reset
            st.sda_sync <= 3'h7;
            st.regs[srapi_pkg::R_DAY] <= srapi_pkg::RST_DAY;
            st.regs[srapi_pkg::R_MONTH] <= srapi_pkg::RST_MONTH;
            st.regs[srapi_pkg::R_CTRL] <= srapi_pkg::RST_CTRL; // clock output on
            st.regs[srapi_pkg::R_FLAGS] <= srapi_pkg::RST_FLAGS; // time unknown
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // outputs; open-drain pins pull low while their enable is high
    // --------------------------------------------------------------
    assign o_sda_out = 1'b0;
    assign o_sda_oe = st.sda_oe;
    assign o_periodic_irq_out_oe = st.regs[srapi_pkg::R_FLAGS][srapi_pkg::B_F_PER];
    assign o_weekly_alarm_irq_out_oe = st.regs[srapi_pkg::R_FLAGS][srapi_pkg::B_F_WK];
    assign o_daily_alarm_irq_out_oe = st.regs[srapi_pkg::R_FLAGS][srapi_pkg::B_F_DY];
    assign o_khz_clock_out_oe = st.khz_oe;
    assign o_avs_readdata = st.av_rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st.av_ack;

endmodule

`default_nettype wire

// ===== pkg/srapi_pkg.sv
// shared constants and types of the serial real-time clock block
package srapi_pkg;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int OSC_HALT_US = 1000;
    localparam int OSC_HALT_CYC = OSC_HALT_US * (CLK_HZ / 1_000_000);
    localparam logic [15:0] PRESC_TOP = 16'h7FFF;
    localparam logic [15:0] PRESC_HALF = 16'h3FFF;
    localparam logic [6:0] DEV_ADDR = 7'h32;

    // --------------------------------------------------------------
    // register indices (avalon word address = index)
    // --------------------------------------------------------------
    localparam logic [3:0] R_SEC = 4'h0;
    localparam logic [3:0] R_MIN = 4'h1;
    localparam logic [3:0] R_HOUR = 4'h2;
    localparam logic [3:0] R_WDAY = 4'h3;
    localparam logic [3:0] R_DAY = 4'h4;
    localparam logic [3:0] R_MONTH = 4'h5;
    localparam logic [3:0] R_YEAR = 4'h6;
    localparam logic [3:0] R_ADJUST = 4'h7;
    localparam logic [3:0] R_WK_MIN = 4'h8;
    localparam logic [3:0] R_WK_HOUR = 4'h9;
    localparam logic [3:0] R_WK_DAYS = 4'hA;
    localparam logic [3:0] R_DY_MIN = 4'hB;
    localparam logic [3:0] R_DY_HOUR = 4'hC;
    localparam logic [3:0] R_RSVD = 4'hD;
    localparam logic [3:0] R_CTRL = 4'hE;
    localparam logic [3:0] R_FLAGS = 4'hF;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int B_CENTURY = 7;
    localparam int B_PM = 5;
    localparam int B_ADJ_SIGN = 6;
    localparam int B_WK_EN = 7;
    localparam int B_DY_EN = 6;
    localparam int B_MODE24 = 5;
    localparam int B_KHZ_OFF = 4;
    localparam int B_VDET_SEL = 3;
    localparam int B_F_VDET = 7;
    localparam int B_F_OSCHALT = 6;
    localparam int B_F_WK = 5;
    localparam int B_F_DY = 4;
    localparam int B_F_PER = 2;

    // periodic select codes in ctrl[2:0]
    localparam logic [2:0] PER_HALF_SEC = 3'h1;
    localparam logic [2:0] PER_SEC = 3'h2;
    localparam logic [2:0] PER_MIN = 3'h3;
    localparam logic [2:0] PER_HOUR = 3'h4;
    localparam logic [2:0] PER_DAY = 3'h5;
    localparam logic [2:0] PER_MONTH = 3'h6;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_CTRL = 8'h20;
    localparam logic [7:0] RST_FLAGS = 8'h40;

    typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_WORD, I2C_DATA, I2C_READ} srapi_i2c_e;

    typedef struct packed {
        logic [15:0][7:0] regs;
        logic [15:0] presc;
        logic [15:0] osc_cnt;
        logic [2:0] xtal_sync;
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [1:0] vlo_sync;
        logic [1:0] vhi_sync;
        srapi_i2c_e i2c_st;
        logic [3:0] bitcnt;
        logic ack_ph;
        logic nack;
        logic [7:0] shreg;
        logic [3:0] ptr;
        logic sda_oe;
        logic khz_oe;
        logic av_ack;
        logic [31:0] av_rdata;
    } srapi_state_s;

endpackage

// ===== tb/serial_rtc_alarm_periodic_irq_bench.sv
// self-checking bench for the rtc core
`timescale 1ns/1ps
`default_nettype none
module serial_rtc_alarm_periodic_irq_bench;
    logic i_clk, i_reset, xtal, xrun, vlo, vhi, rd, wr, scl, sda_low, sda_oe;
    logic per, wk, dy, khz, wq, wq_pre;
    logic [3:0] adr;
    logic [31:0] wd, rdq, rd_pre;
    logic [7:0] xc, q;
    logic [2:0] acks;
    int t;
    int n_errors = 0;
    int n_checks = 0;
    wire sda_w = ~(sda_low | sda_oe);
    srapi_core #(.OSC_HALT_CYCLES(400), .PRESC_TOP(16'h0001)) srapi_core_i (.i_clk(i_clk),
        .i_reset(i_reset), .i_xtal(xtal), .i_vdet_low(vlo), .i_vdet_high(vhi), .i_scl(scl),
        .i_sda(sda_w), .o_sda_out(), .o_sda_oe(sda_oe), .o_periodic_irq_out_oe(per),
        .o_weekly_alarm_irq_out_oe(wk), .o_daily_alarm_irq_out_oe(dy),
        .o_khz_clock_out_oe(khz), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdq), .o_avs_waitrequest(wq));
    srapi_host srapi_host_i (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // crystal of 8 cycles, two rises a second; stopping it provokes the halt detector
    always @(posedge i_clk) begin
        xc <= (xc == 8'h03) ? 8'h00 : xc + 8'h01;
        if (xrun && xc == 8'h03) xtal <= ~xtal;
    end
    // values just before each rising edge, so no edge races the bus
    always @(negedge i_clk) begin
        wq_pre <= wq;
        rd_pre <= rdq;
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp=%h got=%h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge i_clk);
        wr <= w;
        rd <= ~w;
        adr <= a;
        wd <= {24'h000000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (wq_pre !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_errors++;
            test_done();
        end
        r = rd_pre[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] r;
        acc(1'b0, a, 8'h00, r);
        chk(nm, e, r);
    endtask
    // counts clock-pin changes over 400 cycles, sampled where settled
    task automatic togs(output int c);
        logic lst;
        c = 0;
        lst = khz;
        repeat (400) @(negedge i_clk) begin
            if (khz !== lst) c++;
            lst = khz;
        end
    endtask
    initial begin
        {xtal, vlo, vhi, rd, wr, adr, wd, xc} = '0;
        i_reset = 1'b1;
        xrun = 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
        chk("irq_pins", 8'h00, {5'h00, per, wk, dy});
        rdchk("ctrl", srapi_pkg::R_CTRL, srapi_pkg::RST_CTRL);
        rdchk("flags", srapi_pkg::R_FLAGS, srapi_pkg::RST_FLAGS);
        rdchk("day", srapi_pkg::R_DAY, srapi_pkg::RST_DAY);
        rdchk("month", srapi_pkg::R_MONTH, srapi_pkg::RST_MONTH);
        togs(t);
        chk("khz_on", 8'h01, {7'h00, t > 1});
        acc(1'b1, srapi_pkg::R_CTRL, srapi_pkg::RST_CTRL | 8'h10, q);
        repeat (2) @(posedge i_clk); // the pin settles one edge after the write
        togs(t);
        chk("khz_off", 8'h00, {7'h00, t > 0});
        acc(1'b1, srapi_pkg::R_FLAGS, 8'h00, q);
        rdchk("flags_clr", srapi_pkg::R_FLAGS, 8'h00);
        xrun <= 1'b0;
        repeat (500) @(posedge i_clk);
        xrun <= 1'b1;
        rdchk("osc_halt", srapi_pkg::R_FLAGS, 8'h40);
        acc(1'b1, srapi_pkg::R_FLAGS, 8'h00, q);
        vhi <= 1'b1;
        repeat (5) @(posedge i_clk);
        rdchk("vdet_hi", srapi_pkg::R_FLAGS, 8'h00);
        vlo <= 1'b1;
        repeat (5) @(posedge i_clk);
        rdchk("vdet_lo", srapi_pkg::R_FLAGS, 8'h80);
        vlo <= 1'b0;
        acc(1'b1, srapi_pkg::R_SEC, 8'h00, q); // a minute of margin for the link checks
        srapi_host_i.write_reg(srapi_pkg::DEV_ADDR, {4'h0, srapi_pkg::R_MIN}, 8'h37, acks);
        chk("acks", 8'h07, {5'h00, acks});
        rdchk("min_link", srapi_pkg::R_MIN, 8'h37);
        srapi_host_i.write_reg(srapi_pkg::DEV_ADDR ^ 7'h01, {4'h0, srapi_pkg::R_MIN}, 8'h12, acks);
        chk("nacks", 8'h00, {5'h00, acks});
        rdchk("min_kept", srapi_pkg::R_MIN, 8'h37);
        acc(1'b1, srapi_pkg::R_WK_DAYS, 8'h02, q);
        acc(1'b1, srapi_pkg::R_HOUR, 8'h23, q);
        acc(1'b1, srapi_pkg::R_MIN, 8'h59, q);
        acc(1'b1, srapi_pkg::R_CTRL, 8'hE3, q);
        acc(1'b1, srapi_pkg::R_FLAGS, 8'h00, q);
        acc(1'b1, srapi_pkg::R_SEC, 8'h59, q);
        repeat (40) @(negedge i_clk);
        chk("irq_set", 8'h07, {5'h00, per, wk, dy});
        rdchk("flags_irq", srapi_pkg::R_FLAGS, 8'h34);
        rdchk("day_roll", srapi_pkg::R_DAY, 8'h02);
        acc(1'b1, srapi_pkg::R_FLAGS, 8'h00, q);
        @(negedge i_clk);
        chk("irq_clr", 8'h00, {5'h00, per, wk, dy});
        acc(1'b1, srapi_pkg::R_RSVD, 8'hFF, q);
        rdchk("rsvd", srapi_pkg::R_RSVD, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire

// ===== tb/srapi_chk.sv
// port-level assertions for the rtc core
`timescale 1ns/1ps
`default_nettype none
module srapi_chk (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_xtal,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_sda_out,
    input wire logic o_periodic_irq_out_oe,
    input wire logic o_weekly_alarm_irq_out_oe,
    input wire logic o_daily_alarm_irq_out_oe,
    input wire logic o_khz_clock_out_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic fl_wr;
    // flags written over the two-wire link are not seen here, so keep that path quiet
    assign fl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == srapi_pkg::R_FLAGS;
    ack_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus request not answered in one cycle");
    idle_wait_a: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait raised with no request");
    rsvd_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == srapi_pkg::R_RSVD |-> o_avs_readdata == 32'h00000000)
        else $error("reserved place read nonzero");
    rst_irq_a: assert property ($fell(i_reset) |-> !o_periodic_irq_out_oe && !o_weekly_alarm_irq_out_oe && !o_daily_alarm_irq_out_oe)
        else $error("irq pin active after reset");
    khz_rise_a: assert property ($rose(o_khz_clock_out_oe) |-> !$past(i_xtal, 3))
        else $error("clock pin pulled low while crystal high");
    sda_od_a: assert property (o_sda_out == 1'b0)
        else $error("data pin drives high");
    per_hold_a: assert property (o_periodic_irq_out_oe && !fl_wr |=> o_periodic_irq_out_oe)
        else $error("periodic irq dropped uncleared");
    wk_hold_a: assert property (o_weekly_alarm_irq_out_oe && !fl_wr |=> o_weekly_alarm_irq_out_oe)
        else $error("weekly irq dropped uncleared");
    dy_hold_a: assert property (o_daily_alarm_irq_out_oe && !fl_wr |=> o_daily_alarm_irq_out_oe)
        else $error("daily irq dropped uncleared");
endmodule
bind srapi_core srapi_chk srapi_chk_i (.*);
`default_nettype wire

// ===== tb/srapi_host.sv
// two-wire host model that drives the rtc target from the far side
`timescale 1ns/1ps
`default_nettype none
module srapi_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // clock idles driven high; data idles released and the board pulls it high
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // data moves only while the clock is low, 800 ns per bit
    task automatic put_bit(input logic b, output logic seen);
        repeat (2) @(posedge i_clk);
        o_sda_low <= ~b;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (2) @(posedge i_clk);
        seen = i_sda;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b0;
    endtask
    // start, address with write bit, index, one data byte, stop
    task automatic write_reg(input logic [6:0] adr, input logic [7:0] idx,
                             input logic [7:0] d, output logic [2:0] acks);
        logic [26:0] frame;
        logic s;
        frame = {adr, 1'b0, 1'b1, idx, 1'b1, d, 1'b1}; // ack slots left released
        @(posedge i_clk);
        o_sda_low <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b0;
        for (int i = 26; i >= 0; i--) begin
            put_bit(frame[i], s);
            if (i % 9 == 0) acks[i / 9] = ~s;
        end
        repeat (2) @(posedge i_clk);
        o_sda_low <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_sda_low <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire
